// file: pkg/ocs_pkg.sv
// ocs_pkg: types and constants for the oscillator clock select block.
// assumes one 200 MHz register clock and APB-style register access.
//
// Overview of operation
// - the frequency field sits in control bits 6..3, resets to 0111 (500 kHz) and 1111 gives 16 MHz.
// - codes 1010, 1001 and 1000 give 500, 250 and 125 kHz taken from the high frequency oscillator.
// - the source field sits in control bits 1..0 and any value 1x selects the internal oscillator block.
// - source value 01 runs the system clock from the secondary oscillator.
// - source value 00 takes the system clock chosen by the three-bit configuration selection.
// - status bit 6 always reads zero and writes to it have no effect.
package ocs_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int OCS_ADDR_W = 12;
    localparam logic [11:0] OCS_OFS_CONTROL = 12'h000;
    localparam logic [11:0] OCS_OFS_STATUS = 12'h004;
    localparam logic [11:0] OCS_OFS_SWITCH = 12'h008;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int OCS_FREQ_LSB = 3;
    localparam int OCS_FREQ_MSB = 6;
    localparam int OCS_SRC_LSB = 0;
    localparam int OCS_SRC_MSB = 1;
    localparam logic [3:0] OCS_FREQ_RESET = 4'h7;
    localparam logic [1:0] OCS_SRC_RESET = 2'h0;
    localparam logic [1:0] OCS_SRC_SECONDARY = 2'h1;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int OCS_ST_SEC_READY = 7;
    localparam int OCS_ST_UNUSED = 6;
    localparam int OCS_ST_OST_DONE = 5;
    localparam int OCS_ST_HF_READY = 4;
    localparam int OCS_ST_LF_READY = 1;
    localparam int OCS_ST_HF_STABLE = 0;
    localparam int OCS_SW_BUSY = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OCS_INT_HF,
        OCS_INT_MF,
        OCS_INT_LF
    } ocs_int_src_type;

    typedef enum logic [1:0] {
        OCS_SYS_CONFIG,
        OCS_SYS_SECONDARY,
        OCS_SYS_INTERNAL
    } ocs_sys_src_type;

    // divide ratio of the chosen oscillator is 2**div_log2
    typedef struct packed {
        ocs_int_src_type src;
        logic [2:0] div_log2;
    } ocs_tap_type;

    typedef struct packed {
        ocs_sys_src_type sys_src;
        ocs_tap_type tap;
    } ocs_route_type;

    typedef struct packed {
        logic sec_ready;
        logic ost_done;
        logic hf_ready;
        logic lf_ready;
        logic hf_stable;
    } ocs_osc_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ocs_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ocs_apb_rsp_type;

    localparam ocs_tap_type OCS_TAP_RESET = '{src: OCS_INT_MF,
                                               div_log2: 3'h0};

endpackage

// file: rtl/ocs_freq_decode.sv
// ocs_freq_decode: maps the frequency select code to an oscillator tap.
// assumes a purely combinational use by the clock select core.
`timescale 1ns/1ps
module ocs_freq_decode
    import ocs_pkg::*;
(
    // select code
    input wire logic [3:0] internal_freq_select_i,
    // decoded tap
    output ocs_tap_type tap_o
);

    function automatic ocs_tap_type decode_tap(input logic [3:0] code);
        ocs_tap_type t;
        t.src = OCS_INT_MF;
        t.div_log2 = 3'h0;
        unique casez (code)
            4'b1111: t = '{OCS_INT_HF, 3'h0};
            4'b1110: t = '{OCS_INT_HF, 3'h1};
            4'b1101: t = '{OCS_INT_HF, 3'h2};
            4'b1100: t = '{OCS_INT_HF, 3'h3};
            4'b1011: t = '{OCS_INT_HF, 3'h4};
            4'b1010: t = '{OCS_INT_HF, 3'h5};
            4'b1001: t = '{OCS_INT_HF, 3'h6};
            4'b1000: t = '{OCS_INT_HF, 3'h7};
            4'b0111: t = '{OCS_INT_MF, 3'h0};
            4'b0110: t = '{OCS_INT_MF, 3'h1};
            4'b0101: t = '{OCS_INT_MF, 3'h2};
            4'b0100: t = '{OCS_INT_MF, 3'h3};
            4'b001?: t = '{OCS_INT_MF, 3'h4};
            4'b000?: t = '{OCS_INT_LF, 3'h0};
        endcase
        return t;
    endfunction

    assign tap_o = decode_tap(internal_freq_select_i);

endmodule // ocs_freq_decode

// file: rtl/ocs_status_capture.sv
// ocs_status_capture: registers oscillator state and builds status byte.
// assumes the state inputs are synchronous to sys_clk_i.
`timescale 1ns/1ps
module ocs_status_capture
    import ocs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // raw oscillator state
    input ocs_osc_state_type osc_state_i,
    // registered state and status byte
    output ocs_osc_state_type osc_state_o,
    output logic [7:0] status_byte_o
);

    ocs_osc_state_type state;
    ocs_osc_state_type next_state;
    logic [7:0] next_byte;

    always_comb begin
        next_state = osc_state_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        next_byte = 8'h00;
        next_byte[OCS_ST_SEC_READY] = state.sec_ready;
        next_byte[OCS_ST_UNUSED] = 1'b0;
        next_byte[OCS_ST_OST_DONE] = state.ost_done;
        next_byte[OCS_ST_HF_READY] = state.hf_ready;
        next_byte[OCS_ST_LF_READY] = state.lf_ready;
        next_byte[OCS_ST_HF_STABLE] = state.hf_stable;
    end

    assign osc_state_o = state;
    assign status_byte_o = next_byte;

endmodule // ocs_status_capture

// file: rtl/ocs_clock_select.sv
// ocs_clock_select: oscillator control/status registers on APB and the
// glitch-safe routing of the system clock source.
// assumes a single APB master on sys_clk_i and oscillator state inputs
// already synchronous to that clock.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module ocs_clock_select
    import ocs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // register bus
    input ocs_apb_req_type apb_req_i,
    output ocs_apb_rsp_type apb_rsp_o,
    // oscillator state
    input ocs_osc_state_type osc_state_i,
    input wire logic [2:0] config_osc_select_i,
    // clock routing
    output ocs_route_type route_o,
    output logic [2:0] config_osc_select_o,
    output logic switch_busy_o
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    function automatic ocs_sys_src_type decode_src(
        input logic [1:0] src_field);
        ocs_sys_src_type s;
        if (src_field[1]) begin
            s = OCS_SYS_INTERNAL;
        end else if (src_field == OCS_SRC_SECONDARY) begin
            s = OCS_SYS_SECONDARY;
        end else begin
            s = OCS_SYS_CONFIG;
        end
        return s;
    endfunction

    // the medium tap has no ready flag of its own, so it never stalls
    function automatic logic tap_ready(input ocs_tap_type t,
                                       input ocs_osc_state_type st);
        logic ok;
        ok = 1'b1;
        unique case (t.src)
            OCS_INT_HF: ok = st.hf_ready;
            OCS_INT_LF: ok = st.lf_ready;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // secondary, HF and LF targets must be running before the switch is let through
    function automatic logic target_ready(input ocs_route_type r,
                                          input ocs_osc_state_type st);
        logic ok;
        ok = 1'b1;
        unique case (r.sys_src)
            OCS_SYS_SECONDARY: ok = st.sec_ready;
            OCS_SYS_INTERNAL: ok = tap_ready(r.tap, st);
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    function automatic logic addr_is(input logic [11:0] a,
                                     input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // control byte as software sees it; bits 7 and 2 are not stored
    function automatic logic [7:0] pack_control(input logic [3:0] freq,
                                                input logic [1:0] src);
        logic [7:0] b;
        b = 8'h00;
        b[OCS_FREQ_MSB:OCS_FREQ_LSB] = freq;
        b[OCS_SRC_MSB:OCS_SRC_LSB] = src;
        return b;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return addr_is(a, OCS_OFS_CONTROL) || addr_is(a, OCS_OFS_STATUS)
            || addr_is(a, OCS_OFS_SWITCH);
    endfunction

    // one read mux for all mapped offsets; anything else reads zero
    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input logic [7:0] ctl,
                                              input logic [7:0] st,
                                              input logic busy);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (addr_is(a, OCS_OFS_CONTROL)) begin
            w[7:0] = ctl;
        end else if (addr_is(a, OCS_OFS_STATUS)) begin
            w[7:0] = st;
        end else if (addr_is(a, OCS_OFS_SWITCH)) begin
            w[OCS_SW_BUSY] = busy;
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum {
        OCS_ST_STEADY,
        OCS_ST_SWITCH
    } ocs_fsm_type;

    logic [3:0] internal_freq_select;
    logic [3:0] next_internal_freq_select;
    logic [1:0] system_clock_source_select;
    logic [1:0] next_system_clock_source_select;

    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic slverr;
    logic next_slverr;

    ocs_fsm_type fsm;
    ocs_fsm_type next_fsm;
    ocs_route_type route;
    ocs_route_type next_route;
    ocs_route_type wanted;
    logic [2:0] cfg_sel;
    logic [2:0] next_cfg_sel;

    ocs_tap_type wanted_tap;
    ocs_osc_state_type osc_state;
    logic [7:0] status_byte;
    logic [7:0] control_byte;

    logic setup_phase;
    logic access_phase;
    logic wr_control;
    logic hit_any;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    ocs_freq_decode u_freq_decode (
        .internal_freq_select_i(internal_freq_select),
        .tap_o(wanted_tap)
    );

    ocs_status_capture u_status (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .osc_state_i(osc_state_i),
        .osc_state_o(osc_state),
        .status_byte_o(status_byte)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign setup_phase = apb_req_i.psel && !apb_req_i.penable;
    assign access_phase = apb_req_i.psel && apb_req_i.penable;
    assign hit_any = is_mapped(apb_req_i.paddr);
    assign wr_control = access_phase && apb_req_i.pwrite
                     && addr_is(apb_req_i.paddr, OCS_OFS_CONTROL);

    assign control_byte = pack_control(internal_freq_select,
                                       system_clock_source_select);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_comb begin
        next_internal_freq_select = internal_freq_select;
        next_system_clock_source_select = system_clock_source_select;
        if (wr_control) begin
            // bits 7 and 2 of the write word have no storage
            // frequency and source field write
            next_internal_freq_select =
                apb_req_i.pwdata[OCS_FREQ_MSB:OCS_FREQ_LSB];
            next_system_clock_source_select =
                apb_req_i.pwdata[OCS_SRC_MSB:OCS_SRC_LSB];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            internal_freq_select <= OCS_FREQ_RESET;
            system_clock_source_select <= OCS_SRC_RESET;
        end else begin
            internal_freq_select <= next_internal_freq_select;
            system_clock_source_select <= next_system_clock_source_select;
        end
    end

    // ------------------------------------------------------------
    // read data and error
    // ------------------------------------------------------------
    // read data is latched in the setup cycle so prdata is a flop output
    // and the slave can answer with zero wait states.
    always_comb begin
        next_rdata = rdata;
        next_slverr = slverr;
        if (setup_phase) begin
            next_rdata = read_word(apb_req_i.paddr, control_byte,
                                   status_byte, fsm == OCS_ST_SWITCH);
            next_slverr = !hit_any;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata <= 32'h0000_0000;
            slverr <= 1'b0;
        end else begin
            rdata <= next_rdata;
            slverr <= next_slverr;
        end
    end

    always_comb begin
        apb_rsp_o.prdata = rdata;
        apb_rsp_o.pready = 1'b1;
        apb_rsp_o.pslverr = access_phase && slverr;
    end

    // ------------------------------------------------------------
    // requested route
    // ------------------------------------------------------------
    always_comb begin
        wanted.sys_src = decode_src(system_clock_source_select);
        wanted.tap = wanted_tap;
    end

    // ------------------------------------------------------------
    // switch sequencer
    // ------------------------------------------------------------
    // the applied route moves to a secondary, HF or LF target once it reports
    // ready, to config or MF at once; such a target that never comes up leaves the old clock running.
    always_comb begin
        next_fsm = fsm;
        next_route = route;
        unique case (fsm)
            OCS_ST_STEADY: begin
                if (wanted != route) begin
                    next_fsm = OCS_ST_SWITCH;
                end
            end
            OCS_ST_SWITCH: begin
                // a write back to the applied route cancels the wait
                if (wanted == route) begin
                    next_fsm = OCS_ST_STEADY;
                end else if (target_ready(wanted, osc_state)) begin
                    next_route = wanted;
                    next_fsm = OCS_ST_STEADY;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fsm <= OCS_ST_STEADY;
            // source field resets to 00, the configuration source
            route.sys_src <= OCS_SYS_CONFIG;
            route.tap <= OCS_TAP_RESET;
        end else begin
            fsm <= next_fsm;
            route <= next_route;
        end
    end

    // ------------------------------------------------------------
    // configuration selection
    // ------------------------------------------------------------
    always_comb begin
        // config selection passed on
        // one flop, so the copy lines up with the registered route
        next_cfg_sel = config_osc_select_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cfg_sel <= 3'h0;
        end else begin
            cfg_sel <= next_cfg_sel;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign route_o = route;
    assign config_osc_select_o = cfg_sel;
    assign switch_busy_o = (fsm == OCS_ST_SWITCH);

endmodule // ocs_clock_select

// file: sim/ocs_clock_select_props.sv
// ocs_clock_select_props: port assertions for the clock select block.
// assumes it is bound into ocs_clock_select; one clock, sync reset.
`timescale 1ns/1ps
module ocs_clock_select_props
    import ocs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // register bus
    input ocs_apb_req_type apb_req_i,
    input ocs_apb_rsp_type apb_rsp_o,
    // oscillator side
    input ocs_osc_state_type osc_state_i,
    input wire logic [2:0] config_osc_select_i,
    input ocs_route_type route_o,
    input wire logic [2:0] config_osc_select_o,
    input wire logic switch_busy_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic acc, rd, wr_ctl, rd_ctl, rd_st, rdy_q, rdy2;
    logic [3:0] code_q;
    logic [1:0] wsrc;
    assign acc = apb_req_i.psel & apb_req_i.penable;
    assign rd = acc & ~apb_req_i.pwrite;
    assign wr_ctl = acc & apb_req_i.pwrite &
                    (apb_req_i.paddr == OCS_OFS_CONTROL);
    assign rd_ctl = rd & (apb_req_i.paddr == OCS_OFS_CONTROL);
    assign rd_st = rd & (apb_req_i.paddr == OCS_OFS_STATUS);
    assign wsrc = apb_req_i.pwdata[1:0];
    // status is captured a cycle late, so readiness must be held
    assign rdy2 = rdy_q & (&osc_state_i);
    always_ff @(posedge sys_clk_i) begin
        rdy_q <= &osc_state_i;
        if (wr_ctl) begin
            code_q <= apb_req_i.pwdata[6:3];
        end
    end
    function automatic ocs_tap_type tap_of(input logic [3:0] c);
        if (c[3]) return '{OCS_INT_HF, ~c[2:0]};
        if (c[2]) return '{OCS_INT_MF, {1'b0, ~c[1:0]}};
        if (c[1]) return '{OCS_INT_MF, 3'h4};
        return '{OCS_INT_LF, 3'h0};
    endfunction

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    reset_route_a: assert property (
        $fell(reset_i) |-> route_o == ocs_route_type'{OCS_SYS_CONFIG,
        OCS_TAP_RESET}) else $error("route not at reset value");
    tap_follow_a: assert property (
        wr_ctl && wsrc[1] && rdy2 |-> ##[1:6] route_o.tap == tap_of(code_q))
        else $error("tap does not follow frequency code");
    int_src_a: assert property (
        wr_ctl && wsrc[1] && rdy2 |-> ##[1:6]
        route_o.sys_src == OCS_SYS_INTERNAL)
        else $error("internal source not routed");
    sec_src_a: assert property (
        wr_ctl && wsrc == 2'h1 && rdy2 |-> ##[1:6]
        route_o.sys_src == OCS_SYS_SECONDARY)
        else $error("secondary source not routed");
    cfg_src_a: assert property (
        wr_ctl && wsrc == 2'h0 |-> ##[1:6] route_o.sys_src == OCS_SYS_CONFIG)
        else $error("config source not routed");
    cfg_copy_a: assert property (
        !$past(reset_i) |-> config_osc_select_o == $past(config_osc_select_i))
        else $error("config selection not passed on");
    ctl_unused_a: assert property (
        rd_ctl |-> apb_rsp_o.prdata[31:7] == '0 && !apb_rsp_o.prdata[2])
        else $error("control unused bits not zero");
    st_bit_a: assert property (
        rd_st |-> !apb_rsp_o.prdata[6] && apb_rsp_o.prdata[31:8] == '0)
        else $error("status unused bits not zero");

    sec_write_c: cover property (wr_ctl && wsrc == 2'h1);
    busy_rise_c: cover property ($rose(switch_busy_o));
    status_read_c: cover property (rd_st);
endmodule // ocs_clock_select_props

bind ocs_clock_select ocs_clock_select_props i_ocs_clock_select_props (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o),
    .osc_state_i(osc_state_i),
    .config_osc_select_i(config_osc_select_i),
    .route_o(route_o),
    .config_osc_select_o(config_osc_select_o),
    .switch_busy_o(switch_busy_o)
);

// file: sim/ocs_clock_select_tb.sv
// ocs_clock_select_tb: register-level tests of the clock select block.
// assumes the bound checker and zero-wait APB answers are allowed.
`timescale 1ns/1ps
module ocs_clock_select_tb
    import ocs_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    ocs_apb_req_type req = '0;
    ocs_apb_rsp_type rsp;
    ocs_osc_state_type osc = '1;
    logic [2:0] cfg = 3'h0;
    ocs_route_type route;
    logic [2:0] cfg_o;
    logic busy;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [31:0] d;
    logic err;

    always #2.5 sys_clk_i = ~sys_clk_i;

    ocs_clock_select i_ocs_clock_select (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .apb_req_i(req),
        .apb_rsp_o(rsp),
        .osc_state_i(osc),
        .config_osc_select_i(cfg),
        .route_o(route),
        .config_osc_select_o(cfg_o),
        .switch_busy_o(busy)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd);
        @(posedge sys_clk_i);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        // wait for pready; only the bench timeout ends a hung access
        do begin
            @(posedge sys_clk_i);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic settle();
        int n;
        n = 0;
        repeat (3) @(posedge sys_clk_i);
        while (busy !== 1'b0 && n < 40) begin
            @(posedge sys_clk_i);
            n++;
        end
        repeat (2) @(posedge sys_clk_i);
    endtask

    function automatic ocs_tap_type exp_tap(input logic [3:0] c);
        if (c[3]) return '{OCS_INT_HF, ~c[2:0]};
        if (c[2]) return '{OCS_INT_MF, {1'b0, ~c[1:0]}};
        if (c[1]) return '{OCS_INT_MF, 3'h4};
        return '{OCS_INT_LF, 3'h0};
    endfunction

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        xfer(1'b0, OCS_OFS_CONTROL, 32'h0);
        check(rd, 32'h38);
        check(32'(route), 32'({OCS_SYS_CONFIG, OCS_INT_MF, 3'h0}));
        xfer(1'b1, OCS_OFS_STATUS, 32'hff);
        xfer(1'b0, OCS_OFS_STATUS, 32'h0);
        check(rd, 32'hb3);
        xfer(1'b0, 12'h00c, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        // every code, both source values with the upper bit set
        for (int c = 0; c < 16; c++) begin
            d = 32'({c[3:0], 1'b0, 1'b1, c[0]});
            xfer(1'b1, OCS_OFS_CONTROL, d);
            xfer(1'b0, OCS_OFS_CONTROL, 32'h0);
            check(rd, d);
            settle();
            check(32'(route), 32'({OCS_SYS_INTERNAL, exp_tap(c[3:0])}));
        end
        @(posedge sys_clk_i);
        osc.sec_ready <= 1'b0;
        xfer(1'b1, OCS_OFS_CONTROL, 32'h39);
        settle();
        check(32'(busy), 32'h1);
        xfer(1'b0, OCS_OFS_STATUS, 32'h0);
        check(rd, 32'h33);
        xfer(1'b0, OCS_OFS_SWITCH, 32'h0);
        check(rd, 32'h1);
        osc.sec_ready <= 1'b1;
        settle();
        check(32'(route.sys_src), 32'(OCS_SYS_SECONDARY));
        cfg <= 3'h5;
        xfer(1'b1, OCS_OFS_CONTROL, 32'h38);
        settle();
        check(32'(route.sys_src), 32'(OCS_SYS_CONFIG));
        check(32'(cfg_o), 32'h5);
        // second reset in mid-run restores the default code
        xfer(1'b1, OCS_OFS_CONTROL, 32'h7a);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        xfer(1'b0, OCS_OFS_CONTROL, 32'h0);
        check(rd, 32'h38);
        check(32'(route), 32'({OCS_SYS_CONFIG, OCS_TAP_RESET}));
        check(32'(busy), 32'h0);
        stop_test();
    end
endmodule // ocs_clock_select_tb
